// File: core/ioc_cell_ff.sv
/*
  One io cell flip-flop with capture qualifier and global init.
  Assumes the caller forms the capture pulse from clock edge and enable.
*/
`timescale 1ns/10ps
`default_nettype none

module ioc_cell_ff
  import ioc_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Control
  input  wire logic capture,
  input  wire logic globalHit,
  input  wire logic initValue,
  // Data
  input  wire logic d,
  output logic      q
);

  logic q_ff;

  // Global init wins over a capture in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q_ff <= 1'b0;
    end else if (globalHit) begin
      q_ff <= initValue;
    end else if (capture) begin
      q_ff <= d;
    end
  end

  assign q = q_ff;

endmodule : ioc_cell_ff

`default_nettype wire

// File: core/ioc_io_cell.sv
/*
  Programmable io cell: output buffer or register, three-state variants,
  input buffer and input register, configured over APB.
  Assumes all inputs synchronous to clk; register clocks are sampled levels.
*/
// The APB register port and the placing of the registers were chosen for this implementation.
// Behaviour
// - Output register drives the pad; pad level feeds back into input path.
// - Output register holds its value while its clock enable is low.
// - Input register holds its value while its clock enable is low.
// - Three-state control high releases the pad; low drives buffered or registered data.
// - With control low the three-state register acts as plain output register.
// - Global three-state high releases the pad whatever the data.
// - Power-on and global set/reset load each register with its init choice.
// - Init choice defaults to reset when not configured.
// - Older variant clears registers from the fixed global clear line.
// - Output register inverts data, clock, set/reset and three-state by option.
// - Three-state register also inverts its three-state control by option.
// - Input cell offers an unregistered buffered pad copy beside the register.
// - Input path delay stage by default, bypassed by option.
// - At most one output-path element per cell.
// - At most one input element, except buffer beside the register.
// - Global lines are fixed ports, never routed, yet fully modelled.
`timescale 1ns/10ps
`default_nettype none

`include "ioc_map.svh"

module ioc_io_cell
  import ioc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Fabric output side
  input  wire logic        outData,
  input  wire logic        outClk,
  input  wire logic        outClkEn,
  input  wire logic        outTristate,
  // Fabric input side
  input  wire logic        inClk,
  input  wire logic        inClkEn,
  output logic             inRegQ,
  output logic             inBuffered,
  // Global lines
  input  wire logic        globalSetReset,
  input  wire logic        globalClear,
  input  wire logic        globalTristate,
  // Pad
  input  wire logic        padIn,
  output logic             padOut,
  output logic             padOe
);

  // Software configuration
  logic [`IOC_CFG_MSB:0] cfg_ff;
  logic [31:0]           prdata_ff;
  logic                  pslverr_ff;

  // Sampled register clocks for edge detection, and the pad delay stage
  logic                  outClkPrev_ff;
  logic                  inClkPrev_ff;
  logic                  padDly_ff;

  // Decoded configuration
  ioc_out_sel_t          outSel;
  ioc_in_sel_t           inSel;
  logic                  invData;
  logic                  invOutClk;
  logic                  invGsr;
  logic                  invGts;
  logic                  invTri;
  logic                  outInit;
  logic                  inInit;
  logic                  bypassDelay;
  logic                  legacy;
  logic                  invInClk;

  // Internal nets
  logic                  gsrActive;
  logic                  gtsActive;
  logic                  globalHit;
  logic                  outCapture;
  logic                  inCapture;
  logic                  outRegQ;
  logic                  inRegRaw;
  logic                  dataIn;
  logic                  triLocal;
  logic                  useRegOut;
  logic                  hasTri;
  logic                  outPresent;
  logic                  padLevel;
  logic                  inRegData;
  logic                  inRegUsed;
  logic                  inBufUsed;
  logic                  apbAccess;
  logic                  addrHit;
  logic [31:0]           nxt_prdata;
  logic                  nxt_pslverr;
  logic [31:0]           cfgRstWord;
  logic [31:0]           cfgWrWord;

  // Active edge of a sampled clock, falling when inverted
  function automatic logic edgeHit(input logic cur, input logic prev, input logic inv);
    logic rise;
    logic fall;
    rise = cur & ~prev;
    fall = ~cur & prev;
    edgeHit = inv ? fall : rise;
  endfunction : edgeHit

  // Legal element codes only; anything else means no element
  function automatic ioc_out_sel_t outSelOf(input logic [2:0] code);
    case (code)
      3'b001:  outSelOf = OS_BUF;
      3'b010:  outSelOf = OS_TBUF;
      3'b011:  outSelOf = OS_REG;
      3'b100:  outSelOf = OS_TREG;
      default: outSelOf = OS_NONE;
    endcase
  endfunction : outSelOf

  assign outSel      = outSelOf(cfg_ff[`IOC_CFG_OSEL_HI:`IOC_CFG_OSEL_LO]);
  assign inSel       = ioc_in_sel_t'(cfg_ff[`IOC_CFG_ISEL_HI:`IOC_CFG_ISEL_LO]);
  assign invData     = cfg_ff[`IOC_CFG_INV_D];
  assign invOutClk   = cfg_ff[`IOC_CFG_INV_OCLK];
  assign invGsr      = cfg_ff[`IOC_CFG_INV_GSR];
  assign invGts      = cfg_ff[`IOC_CFG_INV_GTS];
  assign invTri      = cfg_ff[`IOC_CFG_INV_TRI];
  assign outInit     = cfg_ff[`IOC_CFG_OINIT];
  assign inInit      = cfg_ff[`IOC_CFG_IINIT];
  assign bypassDelay = cfg_ff[`IOC_CFG_BYPASS];
  assign legacy      = cfg_ff[`IOC_CFG_LEGACY];
  assign invInClk    = cfg_ff[`IOC_CFG_INV_ICLK];

  // APB slave, zero wait states
  assign apbAccess = psel & penable;
  assign addrHit   = (paddr == `IOC_ADDR_CFG) | (paddr == `IOC_ADDR_STAT);
  assign pready    = 1'b1;

  // Full-width words keep the narrow store free of silent truncation
  assign cfgRstWord = `IOC_CFG_RST;
  assign cfgWrWord  = pwdata & `IOC_CFG_MASK;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_ff <= cfgRstWord[`IOC_CFG_MSB:0];
    end else if (apbAccess && pwrite && paddr == `IOC_ADDR_CFG) begin
      cfg_ff <= cfgWrWord[`IOC_CFG_MSB:0];
    end
  end

  // Read data and error are formed in the setup cycle so they stand in access
  always_comb begin
    nxt_prdata  = `IOC_ZERO32;
    nxt_pslverr = 1'b0;
    if (psel && !penable) begin
      if (!addrHit) begin
        nxt_pslverr = 1'b1;
      end else if (!pwrite && paddr == `IOC_ADDR_CFG) begin
        nxt_prdata[`IOC_CFG_MSB:0] = cfg_ff;
      end else if (!pwrite) begin
        nxt_prdata[`IOC_ST_OUTQ]   = outRegQ;
        nxt_prdata[`IOC_ST_INQ]    = inRegRaw;
        nxt_prdata[`IOC_ST_PADOE]  = padOe;
        nxt_prdata[`IOC_ST_PADLVL] = padLevel;
        nxt_prdata[`IOC_ST_GTS]    = gtsActive;
        nxt_prdata[`IOC_ST_GSR]    = gsrActive;
        nxt_prdata[`IOC_ST_GCLR]   = globalClear;
      end
    end else if (apbAccess) begin
      nxt_prdata  = prdata_ff;
      nxt_pslverr = pslverr_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata_ff  <= `IOC_ZERO32;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff  <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff & apbAccess;

  // global lines modelled as fixed ports
  assign gsrActive = globalSetReset ^ invGsr;
  assign gtsActive = globalTristate ^ invGts;
  // legacy variant uses fixed global clear
  assign globalHit = legacy ? globalClear : gsrActive;

  // Previous samples of the register clocks
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      outClkPrev_ff <= 1'b0;
      inClkPrev_ff  <= 1'b0;
    end else begin
      outClkPrev_ff <= outClk;
      inClkPrev_ff  <= inClk;
    end
  end

  assign outCapture = edgeHit(outClk, outClkPrev_ff, invOutClk) & outClkEn;
  assign dataIn     = outData ^ invData;

  ioc_cell_ff outReg (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .capture   (outCapture),
    .globalHit (globalHit),
    .initValue (outInit & ~legacy),
    .d         (dataIn),
    .q         (outRegQ)
  );

  // Element shape
  assign useRegOut  = (outSel == OS_REG) | (outSel == OS_TREG);
  assign hasTri     = (outSel == OS_TBUF) | (outSel == OS_TREG);
  assign outPresent = (outSel != OS_NONE);
  // unused control behaves as plain buffer or register
  assign triLocal   = hasTri & (outTristate ^ invTri);

  assign padOut = useRegOut ? outRegQ : dataIn;
  assign padOe  = outPresent & ~triLocal & ~gtsActive;

  // driven level feeds back into input path
  assign padLevel = padOe ? padOut : padIn;

  // one-cycle delay stage removes hold need at cost of setup
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      padDly_ff <= 1'b0;
    end else begin
      padDly_ff <= padLevel;
    end
  end

  assign inRegData = bypassDelay ? padLevel : padDly_ff;
  assign inRegUsed = (inSel == IS_REG) | (inSel == IS_REG_BUF);
  assign inBufUsed = (inSel == IS_BUF) | (inSel == IS_REG_BUF);

  assign inCapture = edgeHit(inClk, inClkPrev_ff, invInClk) & inClkEn & inRegUsed;

  ioc_cell_ff master_slave_input_register (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .capture   (inCapture),
    .globalHit (globalHit),
    .initValue (inInit & ~legacy),
    .d         (inRegData),
    .q         (inRegRaw)
  );

  // Unused register reads low at inRegQ; the status read still returns its raw value
  assign inRegQ     = inRegRaw & inRegUsed;
  // buffered pad copy beside the register
  assign inBuffered = padLevel & inBufUsed;

endmodule : ioc_io_cell

`default_nettype wire

// File: core/ioc_map.svh
/*
  Register offsets, field positions and reset values of the io cell.
  Assumes a 12-bit APB byte address and 32-bit data.
*/
`ifndef IOC_MAP_SVH
`define IOC_MAP_SVH

// Byte addresses of the two registers
`define IOC_ADDR_CFG     12'h000
`define IOC_ADDR_STAT    12'h004

// Configuration field positions
`define IOC_CFG_OSEL_LO  0
`define IOC_CFG_OSEL_HI  2
`define IOC_CFG_ISEL_LO  4
`define IOC_CFG_ISEL_HI  5
`define IOC_CFG_INV_D    8
`define IOC_CFG_INV_OCLK 9
`define IOC_CFG_INV_GSR  10
`define IOC_CFG_INV_GTS  11
`define IOC_CFG_INV_TRI  12
`define IOC_CFG_OINIT    13
`define IOC_CFG_IINIT    14
`define IOC_CFG_BYPASS   15
`define IOC_CFG_LEGACY   16
`define IOC_CFG_INV_ICLK 17
`define IOC_CFG_MSB      17

// Writable bits of the configuration word; reset is all register modes off
`define IOC_CFG_MASK     32'h0003_ff37
`define IOC_CFG_RST      32'h0000_0000

// Status field positions
`define IOC_ST_OUTQ      0
`define IOC_ST_INQ       1
`define IOC_ST_PADOE     2
`define IOC_ST_PADLVL    3
`define IOC_ST_GTS       4
`define IOC_ST_GSR       5
`define IOC_ST_GCLR      6

`define IOC_ZERO32       32'h0000_0000

`endif

// File: core/ioc_pkg.sv
/*
  Types of the io cell: output and input element selections.
  Assumes the map header for all numeric positions.
*/
package ioc_pkg;

  // One output-path element at most
  typedef enum logic [2:0] {
    OS_NONE = 3'b000,
    OS_BUF  = 3'b001,
    OS_TBUF = 3'b010,
    OS_REG  = 3'b011,
    OS_TREG = 3'b100
  } ioc_out_sel_t;

  // One input-path element at most, a buffer may join the register
  typedef enum logic [1:0] {
    IS_NONE    = 2'b00,
    IS_BUF     = 2'b01,
    IS_REG     = 2'b10,
    IS_REG_BUF = 2'b11
  } ioc_in_sel_t;

endpackage : ioc_pkg

// File: tb/ioc_io_cell_asserts.sv
/* Assertions on the io cell ports.
   Assumes a shadow of the config word, taken from bus writes, matches the cell. */
`timescale 1ns/10ps
`default_nettype none
`include "ioc_map.svh"
module ioc_io_cell_asserts
  import ioc_pkg::*;
(
  // Clock, reset, bus
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Fabric and globals
  input wire logic        outData,
  input wire logic        outClk,
  input wire logic        outClkEn,
  input wire logic        outTristate,
  input wire logic        inClk,
  input wire logic        inClkEn,
  input wire logic        globalSetReset,
  input wire logic        globalClear,
  input wire logic        globalTristate,
  // Outputs and pad
  input wire logic        inRegQ,
  input wire logic        inBuffered,
  input wire logic        padIn,
  input wire logic        padOut,
  input wire logic        padOe
);
  logic [31:0] cfg_ff;
  logic        oClk_ff, iClk_ff, wr, hit, oEdge, iEdge, oReg, triOff, gtsOn;
  always_ff @(posedge clk) begin
    if (sys_rst) cfg_ff <= `IOC_CFG_RST;
    else if (wr) cfg_ff <= pwdata & `IOC_CFG_MASK;
  end
  // Clock history runs through reset, though the cell clears its clock samples in reset
  always_ff @(posedge clk) begin
    oClk_ff <= outClk;
    iClk_ff <= inClk;
  end
  assign wr = psel & penable & pwrite & (paddr == `IOC_ADDR_CFG);
  assign hit = cfg_ff[16] ? globalClear : globalSetReset ^ cfg_ff[10];
  assign oEdge = outClkEn & (cfg_ff[9] ? oClk_ff & ~outClk : ~oClk_ff & outClk);
  assign iEdge = inClkEn & (cfg_ff[17] ? iClk_ff & ~inClk : ~iClk_ff & inClk);
  assign oReg = cfg_ff[2:0] == OS_REG || cfg_ff[2:0] == OS_TREG;
  assign triOff = (cfg_ff[2:0] == OS_TBUF || cfg_ff[2:0] == OS_TREG) && (outTristate ^ cfg_ff[12]);
  assign gtsOn = globalTristate ^ cfg_ff[11];
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_OUT_CAPTURE: assert property (
    oReg && oEdge && !hit && !wr |=> padOut == ($past(outData) ^ cfg_ff[8])) else $error("output capture wrong");
  AST_OUT_HOLD: assert property (
    oReg && !outClkEn && !hit && !wr |=> $stable(padOut)) else $error("output register moved");
  AST_IN_HOLD: assert property (
    cfg_ff[5] && !inClkEn && !hit && !wr |=> $stable(inRegQ)) else $error("input register moved");
  AST_GLOBAL_INIT: assert property (
    oReg && hit && !wr |=> padOut == (cfg_ff[13] && !cfg_ff[16])) else $error("global init value wrong");
  AST_GTS_RELEASE: assert property (
    gtsOn |-> !padOe) else $error("pad driven under global three-state");
  AST_TRI_RELEASE: assert property (
    triOff |-> !padOe) else $error("pad driven under local three-state");
  AST_DRIVE: assert property (
    cfg_ff[2:0] inside {[1:4]} && !gtsOn && !triOff |-> padOe) else $error("pad not driven");
  AST_FEEDBACK: assert property (
    cfg_ff[4] && padOe |-> inBuffered == padOut) else $error("feedback copy wrong");
  AST_BUF_COPY: assert property (
    cfg_ff[4] && !padOe |-> inBuffered == padIn) else $error("buffered pad copy wrong");
  AST_IN_CAPTURE: assert property (
    cfg_ff[5] && iEdge && !hit && !wr && !padOe && !$past(padOe)
    |=> inRegQ == (cfg_ff[15] ? $past(padIn) : $past(padIn, 2))) else $error("input capture wrong");
endmodule : ioc_io_cell_asserts

bind ioc_io_cell ioc_io_cell_asserts ioc_io_cell_asserts_inst (.*);
`default_nettype wire

// File: tb/ioc_io_cell_tb.sv
/* Self-checking bench of the io cell: pad modes, registers, globals, APB.
   Assumes the pad model answers on padIn and the checker is bound in. */
`timescale 1ns/10ps
`default_nettype none
`include "ioc_map.svh"
module ioc_io_cell_tb
  import ioc_pkg::*;
;
  logic        clk = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdData;
  logic        pready, pslverr, rdErr, inRegQ, inBuffered, padIn, padOut, padOe;
  logic        outData = 1'h0, outClk = 1'h0, outClkEn = 1'h0, outTristate = 1'h0;
  logic        inClk = 1'h0, inClkEn = 1'h1, extEn = 1'h0, extVal = 1'h0;
  logic        globalSetReset = 1'h0, globalClear = 1'h0, globalTristate = 1'h0;
  int          mismatches = 0, cmp_count = 0;
  // Config word, then globalTristate, outTristate, outData, padOe, padOut
  logic [36:0] rows [10] = '{
    {32'h0000_0011, 5'h07}, {32'h0000_0011, 5'h02}, {32'h0000_0011, 5'h14}, {32'h0000_0012, 5'h0c},
    {32'h0000_0012, 5'h07}, {32'h0000_1012, 5'h04}, {32'h0000_0111, 5'h06}, {32'h0000_0811, 5'h04},
    {32'h0000_0811, 5'h17}, {32'h0000_0015, 5'h04}};

  ioc_io_cell ioc_io_cell_inst (.*);
  ioc_pad_model ioc_pad_model_inst (.*);
  always #10 clk = ~clk;

  task automatic conclude();
    if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic apbXfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, wr, a, wd};
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      chk("pready", pready, 32'h1);
      conclude();
    end
    rdData = prdata;
    rdErr = pslverr;
    {psel, penable} <= 2'h0;
  endtask : apbXfer

  // Pulse one strobe for a cycle, then let the capture land
  task automatic strobe(input int w);
    @(posedge clk);
    case (w)
      0: outClk <= 1'h1;
      1: inClk <= 1'h1;
      2: globalSetReset <= 1'h1;
      default: globalClear <= 1'h1;
    endcase
    @(posedge clk);
    {outClk, inClk, globalSetReset, globalClear} <= 4'h0;
    repeat (2) @(posedge clk);
  endtask : strobe

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude();
  end

  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'h0;
    apbXfer(1'h0, `IOC_ADDR_CFG, 32'h0000_0000);
    chk("cfg", rdData, `IOC_CFG_RST);
    apbXfer(1'h0, 12'h008, 32'h0000_0000);
    chk("pslverr", rdErr, 32'h1);
    chk("prdata", rdData, 32'h0);
    foreach (rows[i]) begin
      apbXfer(1'h1, `IOC_ADDR_CFG, rows[i][36:5]);
      {globalTristate, outTristate, outData} <= rows[i][4:2];
      @(posedge clk);
      chk("padOe", padOe, rows[i][1]);
      if (rows[i][1]) begin
        chk("padOut", padOut, rows[i][0]);
        chk("inBuffered", inBuffered, rows[i][0]);
      end
    end
    apbXfer(1'h1, `IOC_ADDR_CFG, 32'h0000_0003);
    {outData, outClkEn} <= 2'h3;
    strobe(0);
    chk("padOut", padOut, 32'h1);
    {outData, outClkEn} <= 2'h0;
    strobe(0);
    chk("padOut", padOut, 32'h1);
    strobe(2);
    chk("padOut", padOut, 32'h0);
    apbXfer(1'h1, `IOC_ADDR_CFG, 32'h0000_2003);
    strobe(2);
    chk("padOut", padOut, 32'h1);
    apbXfer(1'h1, `IOC_ADDR_CFG, 32'h0000_0203);
    {outClk, outClkEn} <= 2'h3;
    repeat (2) @(posedge clk);
    chk("padOut", padOut, 32'h1);
    @(posedge clk) outClk <= 1'h0;
    repeat (2) @(posedge clk);
    chk("padOut", padOut, 32'h0);
    apbXfer(1'h1, `IOC_ADDR_CFG, 32'h0000_0004);
    outData <= 1'h1;
    strobe(0);
    chk("padOut", {padOe, padOut}, 32'h3);
    outTristate <= 1'h1;
    @(posedge clk);
    chk("padOe", padOe, 32'h0);
    apbXfer(1'h1, `IOC_ADDR_CFG, 32'h0001_2003);
    strobe(2);
    chk("padOut", padOut, 32'h1);
    strobe(3);
    chk("padOut", padOut, 32'h0);
    extEn <= 1'h1;
    for (int bp = 1; bp >= 0; bp--) begin
      apbXfer(1'h1, `IOC_ADDR_CFG, bp ? 32'h0000_8020 : 32'h0000_0020);
      extVal <= 1'h0;
      repeat (3) @(posedge clk);
      {inClk, extVal} <= 2'h3;
      @(posedge clk) inClk <= 1'h0;
      repeat (2) @(posedge clk);
      chk("inRegQ", inRegQ, bp);
    end
    inClkEn <= 1'h0;
    strobe(1);
    chk("inRegQ", inRegQ, 32'h0);
    apbXfer(1'h1, `IOC_ADDR_CFG, 32'h0000_0030);
    inClkEn <= 1'h1;
    strobe(1);
    chk("inputs", {inRegQ, inBuffered}, 32'h3);
    // Status: input reg set, pad released at external level 1
    apbXfer(1'h0, `IOC_ADDR_STAT, 32'h0000_0000);
    chk("statErr", rdErr, 32'h0);
    chk("stat", rdData, 32'h0000_000a);
    // Input init set, inverted input clock, bypassed delay
    apbXfer(1'h1, `IOC_ADDR_CFG, 32'h0002_c020);
    strobe(2);
    chk("inRegQ", inRegQ, 32'h1);
    inClk <= 1'h1;
    @(posedge clk) {inClk, extVal} <= 2'h0;
    repeat (2) @(posedge clk);
    chk("inRegQ", inRegQ, 32'h0);
    // Inverted set/reset line is active while the pin is low
    apbXfer(1'h1, `IOC_ADDR_CFG, 32'h0000_2403);
    repeat (2) @(posedge clk);
    chk("padOut", padOut, 32'h1);
    apbXfer(1'h1, `IOC_ADDR_CFG, 32'hffff_ffff);
    apbXfer(1'h0, `IOC_ADDR_CFG, 32'h0000_0000);
    chk("cfgMask", rdData, `IOC_CFG_MASK);
    // Second reset in mid-run
    sys_rst <= 1'h1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'h0;
    chk("rstPins", {padOe, inRegQ, inBuffered}, 32'h0);
    apbXfer(1'h0, `IOC_ADDR_CFG, 32'h0000_0000);
    chk("rstCfg", rdData, `IOC_CFG_RST);
    conclude();
  end
endmodule : ioc_io_cell_tb
`default_nettype wire

// File: tb/ioc_pad_model.sv
/* Far side of the pad: an optional external driver and the wire level.
   Assumes the cell's drive wins over the driver, which the bench leaves enabled after its input tests. */
`timescale 1ns/10ps
`default_nettype none
module ioc_pad_model (
  // Clock
  input  wire logic clk,
  // Cell side
  input  wire logic padOut,
  input  wire logic padOe,
  // External driver
  input  wire logic extEn,
  input  wire logic extVal,
  // Wire level
  output logic      padIn
);
  logic last_ff = 1'h0;
  // No keeper on the pad: an undriven wire flips each cycle
  always @(posedge clk) last_ff <= padIn;
  always_comb padIn = padOe ? padOut : (extEn ? extVal : ~last_ff);
endmodule : ioc_pad_model
`default_nettype wire
